// [logic/aps_pkg.sv]
package aps_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int POR_NS = 10000;
  localparam int POR_CYC = (POR_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_NS = 2000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_SETTLE_US = 2000;
  localparam int REF_SETTLE_CYC = REF_SETTLE_US * CLK_MHZ;
  localparam int SCLK_LOW_KHZ = 4800;
  localparam int SLOW_HALF_CYC =
    (CLK_MHZ * 1000 + 2 * SCLK_LOW_KHZ - 1) / (2 * SCLK_LOW_KHZ);
  localparam int FAST_HALF_CYC = 8;
  // ----------------------------------------
  // Control byte and result
  // ----------------------------------------
  localparam int BIT_START = 7;
  localparam int BIT_UNI = 3;
  localparam int BIT_PM_HI = 1;
  localparam int BIT_PM_LO = 0;
  localparam int RES_BITS = 12;
  localparam int ACCEPT_AFTER = 6;
  localparam int XFER_CLKS = 24;
  localparam int FIRST_RES_RISE = 10;
  localparam int LSB_UV = 610;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    PM_FULL = 2'h0, PM_FAST = 2'h1, PM_REDUCED = 2'h2, PM_NORMAL = 2'h3
  } aps_mode_t;
  typedef enum logic [1:0] {
    CMP_OFF = 2'h0, CMP_REDUCED = 2'h1, CMP_FULL = 2'h2
  } aps_cmp_t;
endpackage

// [logic/aps_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface aps_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic hw_powerdown_n;
  logic dout;
  logic dout_oe_n;
  logic conversion_strobe;
  logic strobe_oe_n;
  modport dev (
    input cs_n, sclk, din, hw_powerdown_n,
    output dout, dout_oe_n, conversion_strobe, strobe_oe_n
  );
  modport host (
    output cs_n, sclk, din, hw_powerdown_n,
    input dout, dout_oe_n, conversion_strobe, strobe_oe_n
  );
endinterface
`default_nettype wire

// [logic/aps_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module aps_fifo #(
  parameter int W = 12,
  parameter int D = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr;
  logic [AW-1:0] rd;
  logic [AW:0] cnt;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt != D[AW:0]);
  assign out_valid = (cnt != '0);
  assign out_data = mem[rd];
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr <= '0;
      rd <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        mem[wr] <= in_data;
        wr <= (wr == AW'(D - 1)) ? '0 : wr + 1'b1;
      end
      if (pop) begin
        rd <= (rd == AW'(D - 1)) ? '0 : rd + 1'b1;
      end
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// [logic/aps_device.sv]
// Behaviour
// - Reset into normal mode, strobe low
// - Reset needs 10us; host waits
// - Data out shifts zeros before first conversion
// - Power mode from byte bits 1:0, or pin
// - 00 full, 01 fast, 10 reduced, 11 normal
// - Comparator and reference power per mode
// - Software power-down waits for conversion end
// - Shutdown pin aborts conversion, overrides mode
// - Serial port stays alive in software power-down
// - Enter programmed mode after each conversion
// - Start bit restores full power at once
// - Latch mode bits of each control byte
// - Ready 2us after full or hardware power-down
// - Fast and reduced modes need no wait
// - Host waits for internal reference settling after shutdown, not after full power-down
// - Host waits 2ms with internal reference
// - Host does dummy conversion after full power-down with external reference
// - Host keeps serial clock at most 4.8MHz in fast and reduced modes
// - Conversion starts on fall after eighth bit
// - New start bit only after result bit 6
// - Strobe one clock, then 12 result bits
// - Straight or two's complement, MSB first
`timescale 1ns/100ps
`default_nettype none
module aps_device
  import aps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  aps_link_if.dev link,
  input wire logic [RES_BITS-1:0] sample_code,
  output logic [1:0] power_mode,
  output logic [1:0] comparator_power,
  output logic reference_on,
  output logic converting,
  output logic ready,
  output logic [7:0] control_byte
);
  typedef enum logic [1:0] {
    CV_IDLE = 2'h0, CV_STROBE = 2'h1, CV_SHIFT = 2'h3
  } aps_cv_t;

  // ----------------------------------------
  // Pin synchronisers and clock edges
  // ----------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sclk_d;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= 4'ha;
      sync2 <= 4'ha;
      sclk_d <= 1'b0;
    end else begin
      sync1 <= {link.hw_powerdown_n, link.din, link.cs_n, link.sclk};
      sync2 <= sync1;
      sclk_d <= sync2[0];
    end
  end
  wire sclk_s = sync2[0];
  wire cs_n_s = sync2[1];
  wire din_s = sync2[2];
  wire hw_off = ~sync2[3];
  wire rise = sclk_s & ~sclk_d;
  wire fall = ~sclk_s & sclk_d;

  // ----------------------------------------
  // Receiver and conversion state
  // ----------------------------------------
  aps_cv_t cv_state;
  logic [3:0] rx_cnt;
  logic [6:0] rx_sh;
  logic byte_done;
  logic [3:0] res_cnt;
  logic [RES_BITS-1:0] res_sh;
  logic awake;
  logic dout;
  logic strobe;
  logic [10:0] por_cnt;
  logic [7:0] wake_cnt;
  logic hw_off_d;

  wire accept_ok = (cv_state == CV_IDLE) ||
    (cv_state == CV_SHIFT && res_cnt >= 4'(ACCEPT_AFTER));
  wire bit_take = rise & ~cs_n_s & ~hw_off;
  wire start_bit = bit_take & (rx_cnt == 4'h0) & din_s & accept_ok;
  wire byte_end = bit_take & (rx_cnt == 4'h7);
  wire conv_go = fall & byte_done & ~cs_n_s;
  wire conv_end = fall & (cv_state == CV_SHIFT) &
    (res_cnt == 4'(RES_BITS));
  wire [RES_BITS-1:0] coded = control_byte[BIT_UNI] ? sample_code :
    {~sample_code[RES_BITS-1], sample_code[RES_BITS-2:0]};
  wire leave_full = start_bit & ~awake &
    (power_mode == PM_FULL);
  wire leave_hw = hw_off_d & ~hw_off;

  // ----------------------------------------
  // Power decode
  // ----------------------------------------
  logic [1:0] next_cmp;
  logic next_ref;
  always_comb begin
    next_cmp = CMP_FULL;
    next_ref = 1'b1;
    if (hw_off) begin
      next_cmp = CMP_OFF;
      next_ref = 1'b0;
    end else if (!awake && cv_state == CV_IDLE) begin
      case (power_mode)
        PM_FULL: begin
          next_cmp = CMP_OFF;
          next_ref = 1'b0;
        end
        PM_FAST: next_cmp = CMP_REDUCED;
        PM_REDUCED: next_cmp = CMP_REDUCED;
        PM_NORMAL: next_cmp = CMP_FULL;
        default: next_cmp = CMP_FULL;
      endcase
    end
  end

  // ----------------------------------------
  // Control byte receiver
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_cnt <= 4'h0;
      rx_sh <= 7'h00;
      byte_done <= 1'b0;
      control_byte <= 8'h00;
      power_mode <= PM_NORMAL;
    end else if (hw_off || cs_n_s) begin
      rx_cnt <= 4'h0;
      byte_done <= hw_off ? 1'b0 : byte_done;
    end else begin
      if (start_bit) begin
        rx_cnt <= 4'h1;
        rx_sh <= 7'h01;
      end else if (byte_end) begin
        rx_cnt <= 4'h0;
        control_byte <= {rx_sh, din_s};
        power_mode <= {rx_sh[0], din_s};
        byte_done <= 1'b1;
      end else if (bit_take && rx_cnt != 4'h0) begin
        rx_cnt <= rx_cnt + 4'h1;
        rx_sh <= {rx_sh[5:0], din_s};
      end
      if (conv_go) begin
        byte_done <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cv_state <= CV_IDLE;
      res_cnt <= 4'h0;
      res_sh <= '0;
      dout <= 1'b0;
      strobe <= 1'b0;
      awake <= 1'b0;
    end else if (hw_off) begin
      cv_state <= CV_IDLE;
      res_cnt <= 4'h0;
      dout <= 1'b0;
      strobe <= 1'b0;
      awake <= 1'b0;
    end else begin
      if (start_bit) begin
        awake <= 1'b1;
      end else if (conv_end) begin
        awake <= 1'b0;
      end
      if (conv_go) begin
        cv_state <= CV_STROBE;
        strobe <= 1'b1;
        res_sh <= coded;
        res_cnt <= 4'h0;
        dout <= 1'b0;
      end else if (fall) begin
        case (cv_state)
          CV_STROBE: begin
            strobe <= 1'b0;
            cv_state <= CV_SHIFT;
            dout <= res_sh[RES_BITS-1];
            res_sh <= {res_sh[RES_BITS-2:0], 1'b0};
            res_cnt <= 4'h1;
          end
          CV_SHIFT: begin
            if (res_cnt == 4'(RES_BITS)) begin
              cv_state <= CV_IDLE;
              dout <= 1'b0;
            end else begin
              dout <= res_sh[RES_BITS-1];
              res_sh <= {res_sh[RES_BITS-2:0], 1'b0};
              res_cnt <= res_cnt + 4'h1;
            end
          end
          CV_IDLE: dout <= 1'b0;
          default: cv_state <= CV_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Power-up timing and status
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      por_cnt <= 11'(POR_CYC);
      wake_cnt <= 8'h00;
      hw_off_d <= 1'b0;
      ready <= 1'b0;
      converting <= 1'b0;
      comparator_power <= CMP_FULL;
      reference_on <= 1'b1;
    end else begin
      hw_off_d <= hw_off;
      if (por_cnt != 11'h000) begin
        por_cnt <= por_cnt - 11'h001;
      end
      if (leave_full || leave_hw || hw_off) begin
        wake_cnt <= 8'(WAKE_CYC);
      end else if (wake_cnt != 8'h00) begin
        wake_cnt <= wake_cnt - 8'h01;
      end
      ready <= (por_cnt == 11'h000) && (wake_cnt == 8'h00) && !hw_off;
      converting <= (cv_state != CV_IDLE) && !hw_off;
      comparator_power <= next_cmp;
      reference_on <= next_ref;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic oe_n;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oe_n <= 1'b1;
    end else begin
      oe_n <= cs_n_s | hw_off;
    end
  end
  assign link.dout = dout;
  assign link.conversion_strobe = strobe;
  assign link.dout_oe_n = oe_n;
  assign link.strobe_oe_n = oe_n;
endmodule
`default_nettype wire

// [logic/aps_host.sv]
`timescale 1ns/100ps
`default_nettype none
module aps_host
  import aps_pkg::*;
#(
  parameter int REF_SETTLE = REF_SETTLE_CYC,
  parameter int FAST_HALF = FAST_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  aps_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [6:0] cmd_bits,
  input wire logic shutdown_req,
  input wire logic use_internal_ref,
  output logic res_valid,
  input wire logic res_ready,
  output logic [RES_BITS-1:0] res_data
);
  typedef enum logic [1:0] {
    H_SETTLE = 2'h0, H_IDLE = 2'h1, H_XFER = 2'h3, H_DONE = 2'h2
  } aps_hst_t;

  // ----------------------------------------
  // Data out synchroniser and FIFO
  // ----------------------------------------
  logic dout_s1;
  logic dout_s;
  logic fifo_in_ready;
  logic push;
  logic [RES_BITS-1:0] rx;
  aps_fifo #(.W(RES_BITS), .D(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(rx),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  // ----------------------------------------
  // Transfer sequencer and clock divider
  // ----------------------------------------
  aps_hst_t st;
  logic [17:0] settle;
  logic [4:0] half;
  logic [4:0] rcnt;
  logic [7:0] tx;
  logic [7:0] cur;
  logic [1:0] last_mode;
  logic dummy;
  logic sclk;
  logic cs_n;
  logic din;
  logic pd_n;
  wire take = cmd_valid & cmd_ready;
  wire [7:0] byte_w = {1'b1, cmd_bits};
  wire low_speed = (last_mode == PM_FAST) || (last_mode == PM_REDUCED);
  wire [4:0] half_len = low_speed ? 5'(SLOW_HALF_CYC - 1) :
    5'(FAST_HALF - 1);
  wire [17:0] wake_len = use_internal_ref ? 18'(REF_SETTLE) :
    18'(WAKE_CYC);
  wire [4:0] rnext = rcnt + 5'h01;
  wire in_res = (rnext >= 5'(FIRST_RES_RISE)) &&
    (rnext < 5'(FIRST_RES_RISE + RES_BITS));
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dout_s1 <= 1'b0;
      dout_s <= 1'b0;
      st <= H_SETTLE;
      settle <= 18'(POR_CYC);
      half <= 5'h00;
      rcnt <= 5'h00;
      tx <= 8'h00;
      cur <= 8'h00;
      rx <= '0;
      last_mode <= PM_NORMAL;
      dummy <= 1'b0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      din <= 1'b0;
      pd_n <= 1'b1;
      push <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      dout_s1 <= link.dout;
      dout_s <= dout_s1;
      pd_n <= ~shutdown_req;
      push <= 1'b0;
      cmd_ready <= (st == H_IDLE) && !take && !push && fifo_in_ready &&
        !shutdown_req;
      if (shutdown_req) begin
        st <= H_SETTLE;
        settle <= wake_len;
        cs_n <= 1'b1;
        sclk <= 1'b0;
        din <= 1'b0;
      end else begin
        case (st)
          H_SETTLE: begin
            if (settle == 18'h00000) begin
              st <= H_IDLE;
            end else begin
              settle <= settle - 18'h00001;
            end
          end
          H_IDLE: begin
            if (take) begin
              dummy <= (last_mode == PM_FULL) && !use_internal_ref;
              last_mode <= byte_w[BIT_PM_HI:BIT_PM_LO];
              cur <= byte_w;
              tx <= {byte_w[6:0], 1'b0};
              din <= byte_w[BIT_START];
              cs_n <= 1'b0;
              rcnt <= 5'h00;
              half <= half_len;
              st <= H_XFER;
            end
          end
          H_XFER: begin
            if (half != 5'h00) begin
              half <= half - 5'h01;
            end else begin
              half <= half_len;
              sclk <= ~sclk;
              if (!sclk) begin
                rcnt <= rnext;
                if (in_res) begin
                  rx <= {rx[RES_BITS-2:0], dout_s};
                end
              end else if (rcnt == 5'(XFER_CLKS)) begin
                st <= H_DONE;
                cs_n <= 1'b1;
              end else begin
                din <= tx[7];
                tx <= {tx[6:0], 1'b0};
              end
            end
          end
          H_DONE: begin
            if (dummy) begin
              dummy <= 1'b0;
              tx <= {cur[6:0], 1'b0};
              din <= cur[BIT_START];
              cs_n <= 1'b0;
              rcnt <= 5'h00;
              half <= half_len;
              st <= H_XFER;
            end else begin
              push <= 1'b1;
              st <= H_IDLE;
            end
          end
          default: st <= H_IDLE;
        endcase
      end
    end
  end
  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.din = din;
  assign link.hw_powerdown_n = pd_n;
endmodule
`default_nettype wire

// [testbench/aps_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module aps_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic hw_powerdown_n,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic conversion_strobe,
  input wire logic strobe_oe_n
);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  logic seen_conv;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) seen_conv <= 1'b0;
    else if (conversion_strobe) seen_conv <= 1'b1;
  end
  chk_reset_strobe_low: assert property (
    !rst_n ##1 !rst_n |-> !conversion_strobe && strobe_oe_n)
    else $error("strobe not low in reset");
  chk_reset_dout_idle: assert property (
    !rst_n ##1 !rst_n |-> !dout && dout_oe_n)
    else $error("data out not idle in reset");
  chk_zero_before_conv: assert property (
    disable iff (!rst_n) !seen_conv |-> !dout)
    else $error("data out not zero before first conversion");
  chk_hw_powerdown_n_stops_all: assert property (
    disable iff (!rst_n) !hw_powerdown_n [*5] |->
      !conversion_strobe && !dout && dout_oe_n)
    else $error("shutdown did not stop the link");
  chk_strobe_one_period: assert property (
    disable iff (!rst_n || !hw_powerdown_n) $rose(conversion_strobe)
      |-> conversion_strobe [*8] ##[6:22] !conversion_strobe)
    else $error("strobe width wrong");
  chk_strobe_after_byte: assert property (
    disable iff (!rst_n) $rose(conversion_strobe) |->
      !cs_n && !$past(cs_n, 100))
    else $error("strobe without a full control byte");
  chk_sclk_half_min: assert property (
    disable iff (!rst_n) $changed(sclk) |=> $stable(sclk) [*4])
    else $error("serial clock half period too short");
  chk_cs_releases_oe: assert property (
    disable iff (!rst_n) cs_n [*6] |-> dout_oe_n && strobe_oe_n)
    else $error("outputs driven while deselected");
endmodule
`default_nettype wire

// [testbench/tb_adc_power_mode_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_adc_power_mode_sequencer
  import aps_pkg::*;
;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic ref_clk, rst_n, cmd_valid, cmd_ready, shutdown_req;
  logic use_internal_ref, res_valid, res_ready, reference_on;
  logic converting, ready;
  logic [6:0] cmd_bits;
  logic [11:0] res_data, sample_code;
  logic [1:0] power_mode, comparator_power;
  logic [7:0] control_byte;
  int bad_count, n_compared, cyc;
  aps_link_if link();
  aps_device aps_device_i(.ref_clk, .rst_n, .link(link.dev),
    .sample_code, .power_mode, .comparator_power, .reference_on,
    .converting, .ready, .control_byte);
  aps_host #(.REF_SETTLE(20)) aps_host_i(.ref_clk, .rst_n,
    .link(link.host), .cmd_valid, .cmd_ready, .cmd_bits, .shutdown_req,
    .use_internal_ref, .res_valid, .res_ready, .res_data);
  aps_assertions aps_assertions_i(.ref_clk, .rst_n, .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din),
    .hw_powerdown_n(link.hw_powerdown_n), .dout(link.dout),
    .dout_oe_n(link.dout_oe_n),
    .conversion_strobe(link.conversion_strobe),
    .strobe_oe_n(link.strobe_oe_n));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task stop_test;
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      stop_test();
    end
  end
  task check_eq(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task send(input logic [6:0] cb, input logic [11:0] code);
    int n;
    n = 0;
    sample_code <= code;
    cmd_bits <= cb;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    cmd_valid <= 1'b0;
    while (converting !== 1'b1 && n < 10000) begin
      @(posedge ref_clk);
      n++;
    end
    check_eq({10'h0, comparator_power}, 12'h2);
    check_eq({11'h0, reference_on}, 12'h1);
  endtask
  task take(input logic [11:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (res_valid !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    check_eq(res_data, exp);
    res_ready <= 1'b1;
    @(posedge ref_clk);
    res_ready <= 1'b0;
  endtask
  task conv(input logic [6:0] cb, input logic [11:0] code);
    logic [11:0] exp;
    logic [1:0] cmp;
    exp = cb[3] ? code : code ^ 12'h800;
    cmp = (cb[1:0] == 2'h3) ? 2'h2 : (cb[1:0] == 2'h0) ? 2'h0 : 2'h1;
    send(cb, code);
    take(exp);
    check_eq({10'h0, power_mode}, {10'h0, cb[1:0]});
    check_eq({10'h0, comparator_power}, {10'h0, cmp});
    check_eq({11'h0, reference_on}, {11'h0, |cb[1:0]});
    check_eq({4'h0, control_byte}, {5'h1, cb});
  endtask
  initial begin
    int n;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_bits = 7'h0;
    shutdown_req = 1'b0;
    use_internal_ref = 1'b0;
    res_ready = 1'b0;
    sample_code = 12'h0;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (20) @(posedge ref_clk);
    check_eq({10'h0, power_mode}, 12'h3);
    check_eq({11'h0, link.conversion_strobe}, 12'h0);
    rst_n <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    check_eq(12'(n >= POR_CYC && n < 5000), 12'h1);
    for (int m = 0; m < 4; m++) begin
      conv({3'h5, 2'h3, 2'(m)}, 12'ha5c + 12'(m));
      conv({3'h2, 2'h0, 2'(m)}, 12'h3f1);
    end
    send(7'h0f, 12'h123);
    shutdown_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check_eq({11'h0, converting}, 12'h0);
    check_eq({11'h0, ready}, 12'h0);
    check_eq({10'h0, power_mode}, 12'h3);
    shutdown_req <= 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check_eq(12'(n >= WAKE_CYC && n < 2000), 12'h1);
    res_ready <= 1'b1;
    repeat (3000) begin
      @(posedge ref_clk);
      if (cmd_ready === 1'b1) break;
    end
    res_ready <= 1'b0;
    @(posedge ref_clk);
    conv(7'h0f, 12'h7ff);
    use_internal_ref <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) send(7'h0f, 12'(i * 273));
    n = 0;
    repeat (600) begin
      @(posedge ref_clk);
      if (cmd_ready !== 1'b0) n++;
    end
    check_eq(12'(n), 12'h0);
    for (int i = 0; i < FIFO_DEPTH; i++) take(12'(i * 273));
    @(posedge ref_clk);
    check_eq({11'h0, res_valid}, 12'h0);
    stop_test();
  end
endmodule
`default_nettype wire
